// ==== rpds_pkg.sv ====
// Constants, state codes and helper functions for the rail power-down sequencer.
// Assumes a 50 MHz system clock and eight converter rails.
package rpds_pkg;
	localparam int NUM_RAILS = 8;
	localparam int NUM_CTL = 4;
	localparam int CLK_MHZ = 50;
	localparam int STEP_US = (NUM_RAILS <= 16) ? 250 : 500;
	localparam int TICK_CYCLES_DFLT = STEP_US * CLK_MHZ;
	localparam int TURN_OFF_DELAY_DELAY_DFLT_MS = 25;
	localparam int TURN_OFF_DELAY_TIMEOUT_DFLT_MS = 25;
	localparam logic [15:0] DELAY_RST = 16'(TURN_OFF_DELAY_DELAY_DFLT_MS * 1000 / STEP_US);
	localparam logic [15:0] TIMEOUT_RST = 16'(TURN_OFF_DELAY_TIMEOUT_DFLT_MS * 1000 / STEP_US);
	localparam logic [3:0] CTL_MASK_RST = 4'h0;
	localparam logic [7:0] FAULT_MASK_RST = 8'h00;
	localparam logic [7:0] PRE_MASK_RST = 8'h00;
	localparam logic WARN_EN_RST = 1'h0;
	localparam logic [11:0] ADR_CTRL = 12'h000;
	localparam logic [11:0] ADR_ON = 12'h004;
	localparam logic [11:0] ADR_OFF = 12'h008;
	localparam logic [11:0] ADR_STAT = 12'h00C;
	localparam logic [3:0] RAIL_REGION = 4'h1;
	localparam logic [2:0] FLD_CTL = 3'h0;
	localparam logic [2:0] FLD_FAULT = 3'h1;
	localparam logic [2:0] FLD_PRE = 3'h2;
	localparam logic [2:0] FLD_DELAY = 3'h3;
	localparam logic [2:0] FLD_TIMEOUT = 3'h4;
	localparam int STAT_EN_LSB = 0;
	localparam int STAT_WARN_LSB = 8;
	localparam int STAT_BUSY_LSB = 16;
	localparam int CTRL_WARN_EN_BIT = 0;

	typedef enum logic [4:0] {
		S_OFF = 5'h01,
		S_ON = 5'h02,
		S_PRE = 5'h04,
		S_DLY = 5'h08,
		S_TMO = 5'h10
	} rpds_state_t;

	// True when any selected input is low.
	function automatic logic rpds_any_low(input logic [7:0] mask, input logic [7:0] lv);
		rpds_any_low = |(mask & ~lv);
	endfunction : rpds_any_low

	// Merges write data into an old word under byte enables.
	function automatic logic [31:0] rpds_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		rpds_merge = r;
	endfunction : rpds_merge
endpackage : rpds_pkg

// ==== rpds_rail_engine.sv ====
// Power-down state machine for one converter rail.
// Assumes synchronised inputs and a shared one-cycle step tick.
`timescale 1ns/100ps
`default_nettype none
module rpds_rail_engine (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic tick,
	input wire logic sw_on,
	input wire logic sw_off,
	input wire logic trigger,
	input wire logic prereq_ok,
	input wire logic pgood_self,
	input wire logic warn_en,
	input wire logic [15:0] delay,
	input wire logic [15:0] timeout,
	output logic en,
	output logic warn_pulse,
	output logic busy
);
	rpds_pkg::rpds_state_t st_q, st_d, off_st;
	logic [15:0] cnt_q, cnt_d;
	logic en_q, en_d, warn_q, warn_d;
	wire logic [16:0] cnt_inc = {1'h0, cnt_q} + 17'h00001;
	wire logic dly_done = tick && (cnt_inc >= {1'h0, delay});
	wire logic tmo_done = tick && (cnt_inc >= {1'h0, timeout});
	wire logic start = trigger | sw_off;
	wire logic drop_now = prereq_ok && (delay == 16'h0000);
	wire logic tmo_hit = (st_q == rpds_pkg::S_TMO) && pgood_self && warn_en && tmo_done;
	wire logic dly_end = ce && (st_q == rpds_pkg::S_DLY) && dly_done;

	assign en = en_q;
	assign warn_pulse = warn_q;
	assign busy = (st_q == rpds_pkg::S_PRE) || (st_q == rpds_pkg::S_DLY) || (st_q == rpds_pkg::S_TMO);
	assign off_st = warn_en ? rpds_pkg::S_TMO : rpds_pkg::S_OFF;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		en_d = en_q;
		warn_d = 1'h0;
		case (st_q)
			rpds_pkg::S_OFF: begin
				if (sw_on && !start) begin
					st_d = rpds_pkg::S_ON;
					en_d = 1'h1;
				end
			end
			rpds_pkg::S_ON: begin
				if (start && drop_now) begin
					st_d = off_st;
					en_d = 1'h0;
					cnt_d = 16'h0000;
				end else if (start) begin
					st_d = rpds_pkg::S_PRE;
				end
			end
			rpds_pkg::S_PRE: begin
				if (prereq_ok) begin
					cnt_d = 16'h0000;
					if (delay == 16'h0000) begin
						st_d = off_st;
						en_d = 1'h0;
					end else begin
						st_d = rpds_pkg::S_DLY;
					end
				end
			end
			rpds_pkg::S_DLY: begin
				if (dly_done) begin
					st_d = off_st;
					en_d = 1'h0;
					cnt_d = 16'h0000;
				end else if (tick) begin
					cnt_d = cnt_inc[15:0];
				end
			end
			rpds_pkg::S_TMO: begin
				if (!pgood_self || !warn_en) begin
					st_d = rpds_pkg::S_OFF;
				end else if (tmo_done) begin
					st_d = rpds_pkg::S_OFF;
					warn_d = 1'h1;
				end else if (tick) begin
					cnt_d = cnt_inc[15:0];
				end
			end
			default: begin
				st_d = rpds_pkg::S_OFF;
				en_d = 1'h0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_q <= rpds_pkg::S_OFF;
			cnt_q <= 16'h0000;
			en_q <= 1'h0;
			warn_q <= 1'h0;
		end else if (ce) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			en_q <= en_d;
			warn_q <= warn_d;
		end
	end

	sequence s_delay_end;
		dly_end;
	endsequence

	sequence s_enable_dropped;
		!en_q && ((st_q == rpds_pkg::S_TMO) || (st_q == rpds_pkg::S_OFF));
	endsequence

	AST_ON_STAYS: assert property (@(posedge sys_clk) disable iff (reset)
		ce && (st_q == rpds_pkg::S_ON) && !start |=> en_q)
		else $error("Rail enable dropped without a power-down trigger.");
	AST_PRE_WAITS: assert property (@(posedge sys_clk) disable iff (reset)
		ce && (st_q == rpds_pkg::S_PRE) && !prereq_ok |=> (st_q == rpds_pkg::S_PRE) && en_q)
		else $error("Power-down proceeded before prerequisites dropped.");
	AST_DELAY_HOLDS: assert property (@(posedge sys_clk) disable iff (reset)
		(st_q == rpds_pkg::S_DLY) |-> en_q && (cnt_q < delay))
		else $error("Enable low or counter past delay during turn-off delay.");
	AST_DELAY_COUNTS: assert property (@(posedge sys_clk) disable iff (reset)
		ce && (st_q == rpds_pkg::S_DLY) && tick && !dly_done |=> (cnt_q == $past(cnt_q) + 16'h0001))
		else $error("Turn-off delay counter did not advance on a step.");
	AST_ZERO_DELAY: assert property (@(posedge sys_clk) disable iff (reset)
		ce && (st_q == rpds_pkg::S_ON) && start && prereq_ok && (delay == 16'h0000) |=> !en_q)
		else $error("Zero turn-off delay did not drop enable at once.");
	AST_TMO_STOPS: assert property (@(posedge sys_clk) disable iff (reset)
		ce && (st_q == rpds_pkg::S_TMO) && !pgood_self |=> (st_q == rpds_pkg::S_OFF) && !warn_q)
		else $error("Timeout did not stop when power-good fell.");
	AST_WARN_CAUSE: assert property (@(posedge sys_clk) disable iff (reset)
		warn_q && $past(ce) |-> $past(tmo_hit))
		else $error("Warning raised without an expired turn-off timeout.");
	AST_NO_TMO_OFF: assert property (@(posedge sys_clk) disable iff (reset)
		ce && !warn_en |=> (st_q != rpds_pkg::S_TMO))
		else $error("Timeout checking active with warnings disabled.");
	AST_SEQ_ORDER: assert property (@(posedge sys_clk) disable iff (reset)
		s_delay_end |=> s_enable_dropped)
		else $error("Enable not dropped right after the turn-off delay.");
endmodule : rpds_rail_engine
`default_nettype wire

// ==== rpds_top.sv ====
// Rail power-down sequencer top: Wishbone registers, input synchronisers, step tick, engines.
// Assumes a classic Wishbone master on sys_clk and asynchronous ctl and pgood pins.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Each rail masks control inputs; a selected low input starts power-down; default none.
// - Each rail masks power-good inputs as fault group; selected low starts power-down.
// - Each rail waits until all selected prerequisite power-good inputs are low.
// - After initiation wait the per-rail delay, default 25 ms, 0.25 ms steps.
// - A zero delay drops the rail enable at once after initiation.
// - Time from enable drop to power-good drop against per-rail timeout, default 25 ms.
// - A global option, off by default, enables the turn-off timeout warning output.
// - With warnings disabled no turn-off timeout checking is done.
// - Timeout resolution is 0.25 ms up to sixteen rails, else 0.50 ms.
module rpds_top #(
	parameter int TICK_CYCLES = rpds_pkg::TICK_CYCLES_DFLT
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [11:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic [3:0] ctl,
	input wire logic [7:0] pgood,
	output logic [7:0] en,
	output logic warn
);
	localparam int NR = rpds_pkg::NUM_RAILS;

	logic ack_q, warn_en_q, warn_out_q;
	logic [31:0] dat_r_q;
	logic [3:0] ctl_m_q, ctl_s_q;
	logic [7:0] pg_m_q, pg_s_q, warn_q;
	logic [15:0] tick_cnt_q;
	logic [3:0] ctl_mask_q [NR];
	logic [7:0] fault_mask_q [NR];
	logic [7:0] pre_mask_q [NR];
	logic [15:0] dly_q [NR];
	logic [15:0] tmo_q [NR];
	logic [7:0] trig, prereq_ok, warn_p, busy, fault_hit;

	wire logic acc = wb_cyc && wb_stb && !ack_q;
	wire logic wr = acc && wb_we;
	wire logic in_rail = (wb_adr[11:8] == rpds_pkg::RAIL_REGION);
	wire logic [2:0] r_idx = wb_adr[7:5];
	wire logic [2:0] r_fld = wb_adr[4:2];
	wire logic tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
	wire logic wr_ctrl = wr && (wb_adr == rpds_pkg::ADR_CTRL);
	wire logic wr_stat = wr && (wb_adr == rpds_pkg::ADR_STAT) && wb_sel[1];
	wire logic [7:0] on_req = (wr && (wb_adr == rpds_pkg::ADR_ON) && wb_sel[0]) ? wb_dat_w[7:0] : 8'h00;
	wire logic [7:0] off_req = (wr && (wb_adr == rpds_pkg::ADR_OFF) && wb_sel[0]) ? wb_dat_w[7:0] : 8'h00;
	wire logic [7:0] warn_clr = wr_stat ? wb_dat_w[15:8] : 8'h00;

	wire logic [31:0] rd_rail =
		(r_fld == rpds_pkg::FLD_CTL) ? {28'h0000000, ctl_mask_q[r_idx]} :
		(r_fld == rpds_pkg::FLD_FAULT) ? {24'h000000, fault_mask_q[r_idx]} :
		(r_fld == rpds_pkg::FLD_PRE) ? {24'h000000, pre_mask_q[r_idx]} :
		(r_fld == rpds_pkg::FLD_DELAY) ? {16'h0000, dly_q[r_idx]} :
		(r_fld == rpds_pkg::FLD_TIMEOUT) ? {16'h0000, tmo_q[r_idx]} : 32'h00000000;
	wire logic [31:0] rd_stat = {8'h00, busy, warn_q, en};
	wire logic [31:0] rd_word =
		in_rail ? rd_rail :
		(wb_adr == rpds_pkg::ADR_CTRL) ? {31'h00000000, warn_en_q} :
		(wb_adr == rpds_pkg::ADR_ON) ? {24'h000000, en} :
		(wb_adr == rpds_pkg::ADR_OFF) ? {24'h000000, en} :
		(wb_adr == rpds_pkg::ADR_STAT) ? rd_stat : 32'h00000000;
	wire logic [31:0] wdat = rpds_pkg::rpds_merge(rd_word, wb_dat_w, wb_sel);

	assign wb_ack = ack_q;
	assign wb_dat_r = dat_r_q;
	assign warn = warn_out_q;

	// Bus answer, input synchronisers, step tick and global state.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack_q <= 1'h0;
			dat_r_q <= 32'h00000000;
			ctl_m_q <= 4'h0;
			ctl_s_q <= 4'h0;
			pg_m_q <= 8'h00;
			pg_s_q <= 8'h00;
			tick_cnt_q <= 16'h0000;
			warn_en_q <= rpds_pkg::WARN_EN_RST;
			warn_q <= 8'h00;
			warn_out_q <= 1'h0;
		end else if (ce) begin
			ack_q <= acc;
			dat_r_q <= acc ? rd_word : dat_r_q;
			ctl_m_q <= ctl;
			ctl_s_q <= ctl_m_q;
			pg_m_q <= pgood;
			pg_s_q <= pg_m_q;
			tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
			warn_en_q <= (wr_ctrl && wb_sel[0]) ? wb_dat_w[rpds_pkg::CTRL_WARN_EN_BIT] : warn_en_q;
			warn_q <= (warn_q & ~warn_clr) | warn_p;
			warn_out_q <= warn_en_q && ((|((warn_q & ~warn_clr) | warn_p)));
		end
	end

	for (genvar i = 0; i < NR; i++) begin : g_rail
		wire logic sel_me = wr && in_rail && (r_idx == 3'(i));
		assign fault_hit[i] = rpds_pkg::rpds_any_low(fault_mask_q[i], pg_s_q);
		assign trig[i] = rpds_pkg::rpds_any_low({4'h0, ctl_mask_q[i]}, {4'h0, ctl_s_q}) | fault_hit[i];
		assign prereq_ok[i] = ~|(pre_mask_q[i] & pg_s_q);

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				ctl_mask_q[i] <= rpds_pkg::CTL_MASK_RST;
				fault_mask_q[i] <= rpds_pkg::FAULT_MASK_RST;
				pre_mask_q[i] <= rpds_pkg::PRE_MASK_RST;
				dly_q[i] <= rpds_pkg::DELAY_RST;
				tmo_q[i] <= rpds_pkg::TIMEOUT_RST;
			end else if (ce && sel_me) begin
				if (r_fld == rpds_pkg::FLD_CTL) begin
					ctl_mask_q[i] <= wdat[3:0];
				end
				if (r_fld == rpds_pkg::FLD_FAULT) begin
					fault_mask_q[i] <= wdat[7:0];
				end
				if (r_fld == rpds_pkg::FLD_PRE) begin
					pre_mask_q[i] <= wdat[7:0];
				end
				if (r_fld == rpds_pkg::FLD_DELAY) begin
					dly_q[i] <= wdat[15:0];
				end
				if (r_fld == rpds_pkg::FLD_TIMEOUT) begin
					tmo_q[i] <= wdat[15:0];
				end
			end
		end

		rpds_rail_engine u_eng (
			.sys_clk(sys_clk),
			.reset(reset),
			.ce(ce),
			.tick(tick),
			.sw_on(on_req[i]),
			.sw_off(off_req[i]),
			.trigger(trig[i]),
			.prereq_ok(prereq_ok[i]),
			.pgood_self(pg_s_q[i]),
			.warn_en(warn_en_q),
			.delay(dly_q[i]),
			.timeout(tmo_q[i]),
			.en(en[i]),
			.warn_pulse(warn_p[i]),
			.busy(busy[i])
		);
	end

	AST_CTL_IGNORED: assert property (@(posedge sys_clk) disable iff (reset)
		ce && en[3] && !busy[3] && (ctl_mask_q[3] == 4'h0) && (fault_mask_q[3] == 8'h00)
		&& !off_req[3] |=> en[3])
		else $error("Rail 3 powered down with no source selected.");
	AST_FAULT_DROP: assert property (@(posedge sys_clk) disable iff (reset)
		ce && en[2] && !busy[2] && fault_hit[2] && prereq_ok[2] && (dly_q[2] == 16'h0000)
		|=> !en[2])
		else $error("Rail 2 ignored a fault-group power-good drop.");
	AST_WARN_GATED: assert property (@(posedge sys_clk) disable iff (reset)
		warn |-> $past(warn_en_q))
		else $error("Warning output raised while warnings disabled.");
endmodule : rpds_top
`default_nettype wire

// ==== rpds_conv_model.sv ====
// Behavioural model of the eight power converters on the rail pins.
// Assumes the enables come from the sequencer on the same system clock.
`timescale 1ns/100ps
`default_nettype none
module rpds_conv_model #(
	parameter int LAT = 2
) (
	input wire logic sys_clk,
	input wire logic [7:0] en,
	input wire logic [7:0] stuck,
	input wire logic [7:0] fault,
	output logic [7:0] pgood
);
	int cnt [8];
	initial begin
		pgood = 8'h00;
		for (int i = 0; i < 8; i++) begin
			cnt[i] = 0;
		end
	end
	always @(posedge sys_clk) begin
		for (int i = 0; i < 8; i++) begin
			if (en[i] == pgood[i]) begin
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
			if (fault[i]) begin
				pgood[i] <= 1'b0;
			end else if (en[i] != pgood[i] && cnt[i] >= LAT && !(stuck[i] && !en[i])) begin
				pgood[i] <= en[i];
			end
		end
	end
endmodule : rpds_conv_model
`default_nettype wire

// ==== tb_rpds_top.sv ====
// Self-checking testbench for the rail power-down sequencer top.
// Assumes the converter model on the rail pins and a short step tick.
`timescale 1ns/100ps
`default_nettype none
module tb_rpds_top;
	localparam int T = 4;
	logic sys_clk, reset, ce, wb_cyc, wb_stb, wb_we, wb_ack, warn;
	logic [11:0] wb_adr;
	logic [3:0] wb_sel, ctl;
	logic [31:0] wb_dat_w, wb_dat_r, q;
	logic [7:0] pgood, en, stuck, fault;
	int fail_count = 0;
	int n_compared = 0;
	int n;
	int cyc_n = 0;
	rpds_top #(.TICK_CYCLES(T)) rpds_top_i (.sys_clk(sys_clk), .reset(reset), .ce(ce),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .ctl(ctl),
		.pgood(pgood), .en(en), .warn(warn));
	rpds_conv_model rpds_conv_model_i (.sys_clk(sys_clk), .en(en), .stuck(stuck),
		.fault(fault), .pgood(pgood));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input int v, input int lo, input int hi, input string m);
		n_compared++;
		if (v < lo || v > hi) begin
			fail_count++;
			$display("unexpected at %0t: %s took %0d", $time, m, v);
		end
	endtask : chk_rng
	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		k = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		wb_sel <= s;
		@(posedge sys_clk);
		while (wb_ack !== 1'b1 && k < 100) begin
			@(posedge sys_clk);
			k++;
		end
		chk_rng(k, 0, 99, "ack wait");
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(q, e, m);
	endtask : rd
	task automatic wait_en(input int r, input logic lv);
		n = 0;
		while (en[r] !== lv && n < 1000) begin
			@(posedge sys_clk);
			n++;
		end
	endtask : wait_en
	function automatic logic [11:0] ra(input int i, input int o);
		ra = 12'(256 + i * 32 + o);
	endfunction : ra
	always @(posedge sys_clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 12'h000;
		wb_sel = 4'h0;
		wb_dat_w = 32'h0;
		ctl = 4'hF;
		stuck = 8'h00;
		fault = 8'h00;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rd(rpds_pkg::ADR_CTRL, 32'h0, "warn option");
		rd(ra(0, 0), 32'h0, "ctl mask");
		rd(ra(7, 4), 32'h0, "fault mask");
		rd(ra(3, 8), 32'h0, "pre mask");
		rd(ra(5, 12), 32'h64, "delay");
		rd(ra(2, 16), 32'h64, "timeout");
		wr(12'h7F0, 32'hFFFFFFFF);
		rd(12'h7F0, 32'h0, "unmapped");
		wr(ra(0, 0), 32'hFFFFFFFF);
		rd(ra(0, 0), 32'hF, "ctl mask width");
		wr(ra(0, 0), 32'h1);
		wr(rpds_pkg::ADR_ON, 32'hFF);
		repeat (8) @(posedge sys_clk);
		rd(rpds_pkg::ADR_STAT, 32'hFF, "all on");
		wr(ra(0, 12), 32'h0);
		ctl <= 4'hD;
		repeat (20) @(posedge sys_clk);
		chk(en, 32'hFF, "unmasked ctl");
		ctl <= 4'hE;
		wait_en(0, 1'b0);
		chk_rng(n, 2, 6, "zero delay");
		ctl <= 4'hF;
		wr(ra(1, 12), 32'h5);
		wr(rpds_pkg::ADR_OFF, 32'h2);
		wait_en(1, 1'b0);
		chk_rng(n, 4 * T - 3, 5 * T + 2, "turn-off delay");
		wr(ra(2, 4), 32'h08);
		wr(ra(2, 12), 32'h0);
		fault <= 8'h08;
		wait_en(2, 1'b0);
		chk_rng(n, 2, 8, "fault group");
		chk(en & 8'h08, 32'h08, "fault source rail");
		fault <= 8'h00;
		wr(ra(4, 8), 32'h20);
		wr(ra(4, 12), 32'h0);
		wr(ra(5, 12), 32'h0);
		wr(rpds_pkg::ADR_OFF, 32'h10);
		repeat (30) @(posedge sys_clk);
		chk(en & 8'h30, 32'h30, "prereq hold");
		wr(rpds_pkg::ADR_OFF, 32'h20);
		wait_en(4, 1'b0);
		chk_rng(n, 1, 14, "prereq release");
		wr(ra(6, 16), 32'h3);
		wr(ra(6, 12), 32'h0);
		stuck <= 8'h40;
		wr(rpds_pkg::ADR_OFF, 32'h40);
		repeat (40) @(posedge sys_clk);
		chk(warn, 32'h0, "warn disabled");
		rd(rpds_pkg::ADR_STAT, 32'h88, "no timeout check");
		wr(rpds_pkg::ADR_CTRL, 32'h1);
		wr(rpds_pkg::ADR_ON, 32'h40);
		repeat (8) @(posedge sys_clk);
		wr(rpds_pkg::ADR_OFF, 32'h40);
		wait_en(6, 1'b0);
		n = 0;
		while (warn !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		chk_rng(n, 2 * T - 1, 3 * T + 4, "timeout warn");
		rd(rpds_pkg::ADR_STAT, 32'h4088, "warn flag");
		bus(1'b1, rpds_pkg::ADR_STAT, 32'h4000, 4'h2);
		chk(warn, 32'h0, "warn cleared");
		wr(ra(7, 16), 32'h14);
		wr(ra(7, 12), 32'h0);
		wr(rpds_pkg::ADR_OFF, 32'h80);
		repeat (120) @(posedge sys_clk);
		chk(warn, 32'h0, "prompt pgood");
		rd(rpds_pkg::ADR_STAT, 32'h08, "final status");
		wr(ra(3, 0), 32'h8);
		wr(ra(3, 12), 32'h0);
		ce <= 1'b0;
		ctl <= 4'h7;
		repeat (10) @(posedge sys_clk);
		chk(en, 32'h08, "frozen by clock enable");
		ce <= 1'b1;
		wait_en(3, 1'b0);
		chk_rng(n, 2, 6, "trigger after clock enable");
		complete_run();
	end
endmodule : tb_rpds_top
`default_nettype wire
